// ---- logic/dal_pkg.sv ----
package dal_pkg;

    // ------------------------------------------------------------------
    // Lock key and data space layout
    // ------------------------------------------------------------------
    localparam logic [31:0] UNLOCK_KEY = 32'h5CC5C55C;
    localparam logic [31:0] KEY_RESET = 32'h00000000;
    localparam logic [15:0] SRAM_START = 16'h7800;
    localparam logic [15:0] SRAM_END = 16'h7FFF;
    localparam logic [15:0] STACK_TOP = 16'h7FFF;
    localparam logic [15:0] EEPROM_START = 16'h1400;
    localparam int EEPROM_PAGE_BYTES = 8;
    localparam int EEPROM_PAGES = 64;
    localparam logic [15:0] EEPROM_END = 16'(32'h1400 + EEPROM_PAGE_BYTES * EEPROM_PAGES - 1);
    localparam logic [15:0] FLASH_START = 16'h8000;
    localparam logic [15:0] LOCK_BASE = 16'h1040;
    localparam logic [15:0] FUSE_BASE = 16'h1050;
    localparam logic [15:0] UROW_BASE = 16'h1080;
    localparam logic [15:0] SIGNATURE_ROW_BASE = 16'h1100;
    localparam logic [15:0] SIGNATURE_ROW_END = 16'h117F;
    localparam int LOCK_BYTES = 4;
    localparam int UROW_BYTES = 64;
    localparam int UROW_AW = 6;

    // ------------------------------------------------------------------
    // Fuse offsets inside the fuse block
    // ------------------------------------------------------------------
    localparam int FUSE_COUNT = 9;
    localparam logic [3:0] FUSE_WATCHDOG = 4'h0;
    localparam logic [3:0] FUSE_BROWNOUT = 4'h1;
    localparam logic [3:0] FUSE_OSCILLATOR = 4'h2;
    localparam logic [3:0] FUSE_SYSTEM_ZERO = 4'h5;
    localparam logic [3:0] FUSE_SYSTEM_ONE = 4'h6;
    localparam logic [3:0] FUSE_CODE_SIZE = 4'h7;
    localparam logic [3:0] FUSE_BOOT_SIZE = 4'h8;
    localparam int WDT_WINDOW_MSB = 7;
    localparam int WDT_WINDOW_LSB = 4;
    localparam int WDT_PERIOD_MSB = 3;
    localparam int WDT_PERIOD_LSB = 0;
    localparam logic [7:0] FUSE_RESET = 8'hFF;
    localparam logic [7:0] TARGET_RESET = 8'h00;
    localparam logic [7:0] INVALID_DATA = 8'hFF;

    // ------------------------------------------------------------------
    // Memory sections seen by the access checker
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        SEC_REG = 4'h0,
        SEC_FLASH = 4'h1,
        SEC_SRAM = 4'h2,
        SEC_EEPROM = 4'h3,
        SEC_UROW = 4'h4,
        SEC_SIGNATURE_ROW = 4'h5,
        SEC_FUSE = 4'h6,
        SEC_LOCK = 4'h7
    } dal_sec_t;

    // Debug transfer states, one-hot.
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_EXT = 5'b00010,
        ST_UROW = 5'b00100,
        ST_URD = 5'b01000,
        ST_ERASE = 5'b10000
    } dal_state_t;

endpackage : dal_pkg

// ---- logic/dal_user_row_mem.sv ----
`timescale 1ns/1ps

// --------------------------------------------------------------------------
// Single-port byte memory with registered read data
// --------------------------------------------------------------------------
module dal_user_row_mem #(
    parameter int DEPTH = 64,
    parameter int AW = 6,
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic ce,
    input wire logic req,
    input wire logic we,
    input wire logic [AW-1:0] addr,
    input wire logic [W-1:0] wdata,
    output logic [W-1:0] rdata
);

    logic [W-1:0] mem [0:DEPTH-1];

    // Contents have no reset, so an erase of the rest of the chip leaves them alone.
    always_ff @(posedge clk) begin
        if (ce && req) begin
            if (we) begin
                mem[addr] <= wdata;
            end
            rdata <= mem[addr];
        end
    end

endmodule : dal_user_row_mem

// ---- logic/dal_access_guard.sv ----
`timescale 1ns/1ps

// Function
// - Unlocked only when key equals unlock value.
// - Locked: refuse debug access, CPU unaffected.
// - Refused debug reads answer with invalid data.
// - Locked: user row writable via fuse command only.
// - Only full chip erase leaves locked state.
// - User row is 64 bytes, survives erase.
// - CPU reads and writes user row freely.
// - Both read fuses; only debug writes them.
// - Fuses copied to targets at start-up end.
// - Changed fuses act only after next reset.
// - SRAM 0x7800-0x7FFF, stack on top, no fetch.
// - EEPROM at 0x1400, 64 pages of 8 bytes.
// - Watchdog fuse nibbles load window and period.
module dal_access_guard
    import dal_pkg::*;
#(
    parameter int FUSES = FUSE_COUNT
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic startup_done,
    input wire logic [31:0] nv_key,
    input wire logic [FUSES*8-1:0] nv_fuse_image,
    input wire logic dbg_req,
    input wire logic dbg_we,
    input wire logic dbg_fuse_cmd,
    input wire logic dbg_erase,
    input wire logic [15:0] dbg_addr,
    input wire logic [7:0] dbg_wdata,
    output logic dbg_ack,
    output logic [7:0] dbg_rdata,
    input wire logic cpu_req,
    input wire logic cpu_we,
    input wire logic [15:0] cpu_addr,
    input wire logic [7:0] cpu_wdata,
    output logic cpu_ack,
    output logic [7:0] cpu_rdata,
    output logic mem_req,
    output logic mem_we,
    output logic [15:0] mem_addr,
    output logic [7:0] mem_wdata,
    input wire logic mem_ack,
    input wire logic [7:0] mem_rdata,
    output logic nv_wr,
    output logic [15:0] nv_wr_addr,
    output logic [7:0] nv_wr_data,
    output logic erase_start,
    input wire logic erase_done,
    input wire logic ifetch_req,
    input wire logic [15:0] ifetch_addr,
    output logic ifetch_fault,
    output logic [15:0] stack_top,
    output logic locked,
    output logic access_ready,
    output logic [3:0] wdt_window,
    output logic [3:0] wdt_period,
    output logic [7:0] bod_cfg,
    output logic [7:0] osc_cfg,
    output logic [7:0] sys_cfg0,
    output logic [7:0] sys_cfg1,
    output logic [7:0] code_size,
    output logic [7:0] boot_size
);

    // ------------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------------

    // Maps a data space address onto its protected section.
    function automatic dal_sec_t sec_of(input logic [15:0] a);
        dal_sec_t s;
        s = SEC_REG;
        if (a >= FLASH_START) begin
            s = SEC_FLASH;
        end else if (a >= SRAM_START && a <= SRAM_END) begin
            s = SEC_SRAM;
        end else if (a >= EEPROM_START && a <= EEPROM_END) begin
            s = SEC_EEPROM;
        end else if (a >= SIGNATURE_ROW_BASE && a <= SIGNATURE_ROW_END) begin
            s = SEC_SIGNATURE_ROW;
        end else if (a >= UROW_BASE && a < UROW_BASE + 16'(UROW_BYTES)) begin
            s = SEC_UROW;
        end else if (a >= FUSE_BASE && a < FUSE_BASE + 16'(FUSES)) begin
            s = SEC_FUSE;
        end else if (a >= LOCK_BASE && a < LOCK_BASE + 16'(LOCK_BYTES)) begin
            s = SEC_LOCK;
        end
        return s;
    endfunction : sec_of

    // Debug link permission for one access in the current lock state.
    function automatic logic dbg_allowed(input dal_sec_t s, input logic wr, input logic fcmd, input logic lk);
        logic ok;
        ok = 1'b0;
        if (lk) begin
            ok = (s == SEC_UROW) && wr && fcmd;
        end else begin
            ok = !(wr && s == SEC_SIGNATURE_ROW);
        end
        return ok;
    endfunction : dbg_allowed

    // ------------------------------------------------------------------
    // State and decode wires
    // ------------------------------------------------------------------
    dal_state_t state;
    logic [31:0] lock_key;
    logic [7:0] fuse_store [0:FUSES-1];
    logic [15:0] hold_addr;
    logic hold_we;
    logic [7:0] hold_wdata;
    logic cpu_p1;
    logic cpu_p1_urow;
    logic [7:0] cpu_p1_data;
    logic [7:0] urow_rdata;

    dal_sec_t dbg_sec;
    dal_sec_t cpu_sec;
    logic dbg_take;
    logic dbg_ok;
    logic cpu_take;
    logic cpu_urow;
    logic urow_req;
    logic urow_we;
    logic [UROW_AW-1:0] urow_addr;
    logic [7:0] urow_wdata;
    logic dbg_urow_go;
    logic [3:0] dbg_fuse_idx;
    logic [3:0] cpu_fuse_idx;
    logic [1:0] dbg_key_idx;
    logic [1:0] cpu_key_idx;
    logic [7:0] dbg_local_rd;
    logic [7:0] cpu_local_rd;

    // Held off until the key is judged; a request still up on its acknowledge is not taken twice.
    assign dbg_take = ce && dbg_req && access_ready && (state == ST_IDLE) && !dbg_ack;
    assign dbg_sec = sec_of(dbg_addr);
    assign dbg_ok = dbg_allowed(dbg_sec, dbg_we, dbg_fuse_cmd, locked);
    assign cpu_take = ce && cpu_req;
    assign cpu_sec = sec_of(cpu_addr);
    assign cpu_urow = cpu_take && (cpu_sec == SEC_UROW);
    assign dbg_fuse_idx = 4'(dbg_addr - FUSE_BASE);
    assign cpu_fuse_idx = 4'(cpu_addr - FUSE_BASE);
    assign dbg_key_idx = 2'(dbg_addr - LOCK_BASE);
    assign cpu_key_idx = 2'(cpu_addr - LOCK_BASE);
    assign dbg_local_rd = (dbg_sec == SEC_LOCK) ? lock_key[8*dbg_key_idx +: 8] : fuse_store[dbg_fuse_idx];
    assign cpu_local_rd = (cpu_sec == SEC_LOCK) ? lock_key[8*cpu_key_idx +: 8] : fuse_store[cpu_fuse_idx];

    // The CPU owns the user row port; a debug access waits for as long as the CPU keeps using it.
    assign dbg_urow_go = (state == ST_UROW) && !cpu_urow && ce;
    assign urow_req = cpu_urow || dbg_urow_go;
    assign urow_we = cpu_urow ? cpu_we : hold_we;
    assign urow_addr = cpu_urow ? UROW_AW'(cpu_addr - UROW_BASE) : UROW_AW'(hold_addr - UROW_BASE);
    assign urow_wdata = cpu_urow ? cpu_wdata : hold_wdata;

    // ------------------------------------------------------------------
    // User row storage
    // ------------------------------------------------------------------
    dal_user_row_mem #(
        .DEPTH(UROW_BYTES),
        .AW(UROW_AW),
        .W(8)
    ) u_user_row (
        .clk(clk),
        .ce(ce),
        .req(urow_req),
        .we(urow_we),
        .addr(urow_addr),
        .wdata(urow_wdata),
        .rdata(urow_rdata)
    );

    // ------------------------------------------------------------------
    // Lock state and key store
    // ------------------------------------------------------------------

    // A new key written over the link only reaches the lock decision at the next start-up.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lock_key <= KEY_RESET;
            locked <= 1'b1;
            access_ready <= 1'b0;
        end else if (ce) begin
            if (startup_done) begin
                lock_key <= nv_key;
                locked <= (nv_key != UNLOCK_KEY);
                access_ready <= 1'b1;
            end else if (state == ST_ERASE && erase_done) begin
                lock_key <= UNLOCK_KEY;
                locked <= 1'b0;
            end else if (dbg_take && dbg_ok && dbg_we && dbg_sec == SEC_LOCK) begin
                lock_key[8*dbg_key_idx +: 8] <= dbg_wdata;
            end
        end
    end

    // ------------------------------------------------------------------
    // Fuse store and target registers
    // ------------------------------------------------------------------

    // Stored fuse bytes follow debug writes at once; CPU writes never reach them.
    genvar gi;
    generate
        for (gi = 0; gi < FUSES; gi++) begin : g_fuse
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    fuse_store[gi] <= FUSE_RESET;
                end else if (ce) begin
                    if (startup_done) begin
                        fuse_store[gi] <= nv_fuse_image[8*gi +: 8];
                    end else if (dbg_take && dbg_ok && dbg_we && dbg_sec == SEC_FUSE &&
                                 dbg_fuse_idx == 4'(gi)) begin
                        fuse_store[gi] <= dbg_wdata;
                    end
                end
            end
        end
    endgenerate

    // Targets load only at the end of start-up, so a changed fuse waits for a reset.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wdt_window <= 4'h0;
            wdt_period <= 4'h0;
            bod_cfg <= TARGET_RESET;
            osc_cfg <= TARGET_RESET;
            sys_cfg0 <= TARGET_RESET;
            sys_cfg1 <= TARGET_RESET;
            code_size <= TARGET_RESET;
            boot_size <= TARGET_RESET;
        end else if (ce && startup_done) begin
            wdt_window <= nv_fuse_image[8*FUSE_WATCHDOG + WDT_WINDOW_LSB +: 4];
            wdt_period <= nv_fuse_image[8*FUSE_WATCHDOG + WDT_PERIOD_LSB +: 4];
            bod_cfg <= nv_fuse_image[8*FUSE_BROWNOUT +: 8];
            osc_cfg <= nv_fuse_image[8*FUSE_OSCILLATOR +: 8];
            sys_cfg0 <= nv_fuse_image[8*FUSE_SYSTEM_ZERO +: 8];
            sys_cfg1 <= nv_fuse_image[8*FUSE_SYSTEM_ONE +: 8];
            code_size <= nv_fuse_image[8*FUSE_CODE_SIZE +: 8];
            boot_size <= nv_fuse_image[8*FUSE_BOOT_SIZE +: 8];
        end
    end

    // ------------------------------------------------------------------
    // Debug link transfer engine
    // ------------------------------------------------------------------

    // A refused access still acknowledges with invalid data, so the link is never left waiting.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= ST_IDLE;
            dbg_ack <= 1'b0;
            dbg_rdata <= 8'h00;
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            mem_addr <= 16'h0000;
            mem_wdata <= 8'h00;
            hold_addr <= 16'h0000;
            hold_we <= 1'b0;
            hold_wdata <= 8'h00;
            nv_wr <= 1'b0;
            nv_wr_addr <= 16'h0000;
            nv_wr_data <= 8'h00;
            erase_start <= 1'b0;
        end else if (ce) begin
            dbg_ack <= 1'b0;
            nv_wr <= 1'b0;
            erase_start <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (dbg_take && dbg_erase) begin
                        erase_start <= 1'b1;
                        state <= ST_ERASE;
                    end else if (dbg_take && !dbg_ok) begin
                        dbg_ack <= 1'b1;
                        dbg_rdata <= INVALID_DATA;
                    end else if (dbg_take && (dbg_sec == SEC_FUSE || dbg_sec == SEC_LOCK)) begin
                        dbg_ack <= 1'b1;
                        dbg_rdata <= dbg_we ? 8'h00 : dbg_local_rd;
                        nv_wr <= dbg_we;
                        nv_wr_addr <= dbg_addr;
                        nv_wr_data <= dbg_wdata;
                    end else if (dbg_take && dbg_sec == SEC_UROW) begin
                        hold_addr <= dbg_addr;
                        hold_we <= dbg_we;
                        hold_wdata <= dbg_wdata;
                        state <= ST_UROW;
                    end else if (dbg_take) begin
                        mem_req <= 1'b1;
                        mem_we <= dbg_we;
                        mem_addr <= dbg_addr;
                        mem_wdata <= dbg_wdata;
                        state <= ST_EXT;
                    end
                end
                ST_EXT: begin
                    if (mem_ack) begin
                        mem_req <= 1'b0;
                        dbg_ack <= 1'b1;
                        dbg_rdata <= mem_we ? 8'h00 : mem_rdata;
                        state <= ST_IDLE;
                    end
                end
                ST_UROW: begin
                    if (dbg_urow_go) begin
                        state <= ST_URD;
                    end
                end
                ST_URD: begin
                    dbg_ack <= 1'b1;
                    dbg_rdata <= hold_we ? 8'h00 : urow_rdata;
                    state <= ST_IDLE;
                end
                ST_ERASE: begin
                    if (erase_done) begin
                        dbg_ack <= 1'b1;
                        dbg_rdata <= 8'h00;
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // CPU port, fetch guard and stack top
    // ------------------------------------------------------------------

    // CPU accesses ignore the lock; a second stage lets the user row read settle.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cpu_p1 <= 1'b0;
            cpu_p1_urow <= 1'b0;
            cpu_p1_data <= 8'h00;
            cpu_ack <= 1'b0;
            cpu_rdata <= 8'h00;
            ifetch_fault <= 1'b0;
            stack_top <= 16'h0000;
        end else if (ce) begin
            cpu_p1 <= cpu_take;
            cpu_p1_urow <= cpu_urow;
            cpu_p1_data <= cpu_local_rd;
            cpu_ack <= cpu_p1;
            cpu_rdata <= cpu_p1_urow ? urow_rdata : cpu_p1_data;
            ifetch_fault <= ifetch_req && (sec_of(ifetch_addr) == SEC_SRAM);
            stack_top <= STACK_TOP;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_KEY_DECIDES: assert property (ce && startup_done |=> locked == ($past(nv_key) != UNLOCK_KEY))
        else $error("lock state does not follow loaded key");
    AST_LOCKED_NO_LINK: assert property (locked |-> !mem_req && !nv_wr)
        else $error("debug access forwarded while locked");
    AST_REFUSED_INVALID: assert property (dbg_take && !dbg_ok && !dbg_erase |=> dbg_ack && dbg_rdata == INVALID_DATA)
        else $error("refused read did not answer invalid data");
    AST_UROW_LOCKED_WR: assert property (dbg_take && !dbg_erase && locked && dbg_sec == SEC_UROW && dbg_we
        && dbg_fuse_cmd |=> state == ST_UROW)
        else $error("locked user row write not accepted");
    AST_ERASE_UNLOCKS: assert property (ce && state == ST_ERASE && erase_done && !startup_done
        |=> !locked && lock_key == UNLOCK_KEY)
        else $error("erase did not unlock");
    AST_ONLY_ERASE_UNLOCKS: assert property ($fell(locked) |-> $past(state == ST_ERASE || startup_done))
        else $error("unlocked without erase");
    AST_FUSE_WR_FROM_LINK: assert property (nv_wr |-> $past(dbg_take && dbg_we))
        else $error("fuse write without debug request");
    AST_TARGETS_HOLD: assert property (!(ce && startup_done) |=> $stable(wdt_window) && $stable(code_size)
        && $stable(sys_cfg0))
        else $error("fuse target changed outside start-up");
    AST_WDT_NIBBLES: assert property (ce && startup_done |=> wdt_window == $past(nv_fuse_image[7:4])
        && wdt_period == $past(nv_fuse_image[3:0]))
        else $error("watchdog nibbles not loaded");
    AST_SRAM_NO_FETCH: assert property (ce && ifetch_req && ifetch_addr >= SRAM_START && ifetch_addr <= SRAM_END
        |=> ifetch_fault)
        else $error("SRAM fetch not flagged");
    AST_WAIT_FOR_KEY: assert property (!access_ready |-> state == ST_IDLE && !dbg_ack)
        else $error("debug access before key load");
    AST_CPU_TWO_CYCLE: assert property (cpu_take |-> ##2 cpu_ack)
        else $error("CPU answer not after two cycles");

    COV_LOCKED_REFUSE: cover property (locked && dbg_take && !dbg_ok ##1 dbg_ack);
    COV_ERASE_UNLOCK: cover property (state == ST_ERASE ##[1:50] !locked);
    COV_UROW_LOCKED: cover property (locked && state == ST_URD);
    COV_EXT_DONE: cover property (state == ST_EXT ##1 mem_ack && mem_req);

endmodule : dal_access_guard

// ---- testbench/dal_mem_model.sv ----
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Memory fabric and erase engine behind the forwarded debug port
// ----------------------------------------------------------------
module dal_mem_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] dly,
    input wire logic mem_req,
    input wire logic [15:0] mem_addr,
    output logic mem_ack,
    output logic [7:0] mem_rdata,
    input wire logic erase_start,
    output logic erase_done
);
    logic [3:0] cnt;
    logic hold;
    logic [1:0] ecnt;

    // Answer after dly cycles, then ignore the request until it drops, so one request gets one answer.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt <= 4'h0;
            hold <= 1'b0;
            mem_ack <= 1'b0;
            mem_rdata <= 8'h00;
        end else begin
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata; // Data only means something beside the acknowledge.
            if (!mem_req) hold <= 1'b0;
            if (cnt != 4'h0) begin
                cnt <= cnt - 4'h1;
                if (cnt == 4'h1) begin
                    mem_ack <= 1'b1;
                    mem_rdata <= mem_addr[7:0] ^ 8'hA5;
                    hold <= 1'b1;
                end
            end else if (mem_req && !hold) begin
                cnt <= dly;
            end
        end
    end

    // The erase takes a few cycles, so the design has to wait for completion.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ecnt <= 2'h0;
            erase_done <= 1'b0;
        end else begin
            erase_done <= (ecnt == 2'h1);
            if (erase_start) ecnt <= 2'h3;
            else if (ecnt != 2'h0) ecnt <= ecnt - 2'h1;
        end
    end
endmodule : dal_mem_model

// ---- testbench/debug_access_lock_and_fuses_tb.sv ----
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Self-checking bench: queued expectations, monitors on the answers
// ----------------------------------------------------------------
module debug_access_lock_and_fuses_tb;
    import dal_pkg::*;
    logic clk, rst, ce, sdone, dreq, dwe, dfuse, derase, dack, creq, cwe, cack, mreq, mwe, mack, nvw, est, edone;
    logic ifreq, ifault, lck, ardy;
    logic [31:0] key;
    logic [71:0] img;
    logic [15:0] daddr, caddr, maddr, nva, ifa, stk;
    logic [7:0] dwd, drd, cwd, crd, mwd, mrd, nvd, bod, osc, s0, s1, csz, bsz;
    logic [3:0] wwin, wper, dly;
    logic [8:0] dq[$], cq[$], dx, cx;
    int fail_count, tests_run, seed;

    dal_access_guard dal_access_guard_i (.clk(clk), .rst(rst), .ce(ce), .startup_done(sdone), .nv_key(key),
        .nv_fuse_image(img), .dbg_req(dreq), .dbg_we(dwe), .dbg_fuse_cmd(dfuse), .dbg_erase(derase),
        .dbg_addr(daddr), .dbg_wdata(dwd), .dbg_ack(dack), .dbg_rdata(drd), .cpu_req(creq), .cpu_we(cwe),
        .cpu_addr(caddr), .cpu_wdata(cwd), .cpu_ack(cack), .cpu_rdata(crd), .mem_req(mreq), .mem_we(mwe),
        .mem_addr(maddr), .mem_wdata(mwd), .mem_ack(mack), .mem_rdata(mrd), .nv_wr(nvw), .nv_wr_addr(nva),
        .nv_wr_data(nvd), .erase_start(est), .erase_done(edone), .ifetch_req(ifreq), .ifetch_addr(ifa),
        .ifetch_fault(ifault), .stack_top(stk), .locked(lck), .access_ready(ardy), .wdt_window(wwin),
        .wdt_period(wper), .bod_cfg(bod), .osc_cfg(osc), .sys_cfg0(s0), .sys_cfg1(s1), .code_size(csz),
        .boot_size(bsz));
    dal_mem_model dal_mem_model_i (.clk(clk), .rst(rst), .dly(dly), .mem_req(mreq), .mem_addr(maddr),
        .mem_ack(mack), .mem_rdata(mrd), .erase_start(est), .erase_done(edone));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task summarize;
        $display("mismatches %0d comparisons %0d", fail_count, tests_run);
        if (fail_count == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : summarize

    // One debug byte transfer; bit 8 of the note asks for a data comparison.
    task dbg(input logic [15:0] a, input logic w, input logic f, input logic e, input logic [7:0] d,
             input logic [8:0] x);
        int n;
        @(posedge clk);
        #2;
        dq.push_back(x);
        daddr = a; dwe = w; dfuse = f; derase = e; dwd = d; dreq = 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (dack !== 1'b1 && n < 200);
        if (n >= 200) begin
            fail_count++;
            summarize();
        end
        #2 dreq = 1'b0;
    endtask : dbg

    // One CPU byte access; the answer comes a fixed two cycles later.
    task cpu(input logic [15:0] a, input logic w, input logic [7:0] d, input logic [8:0] x);
        @(posedge clk);
        #2;
        cq.push_back(x);
        caddr = a; cwe = w; cwd = d; creq = 1'b1;
        @(posedge clk);
        #2 creq = 1'b0;
        repeat (3) @(posedge clk);
    endtask : cpu

    // Monitors take the oldest note whenever an answer shows up.
    always @(posedge clk) begin
        if (dack === 1'b1) begin
            if (dq.size() == 0) chk(16'h1, 16'h0);
            else begin
                dx = dq.pop_front();
                if (dx[8]) chk(drd, dx[7:0]);
            end
        end
        if (cack === 1'b1) begin
            if (cq.size() == 0) chk(16'h1, 16'h0);
            else begin
                cx = cq.pop_front();
                if (cx[8]) chk(crd, cx[7:0]);
            end
        end
    end

    task boot;
        #2 rst = 1'b1;
        repeat (3) @(posedge clk);
        #2 rst = 1'b0;
        @(posedge clk);
        #2 sdone = 1'b1;
        @(posedge clk);
        #2 sdone = 1'b0;
        @(posedge clk);
        #2;
    endtask : boot

    initial begin
        seed = 26;
        fail_count = 0; tests_run = 0;
        ce = 1'b1; sdone = 1'b0; dreq = 1'b0; dwe = 1'b0; dfuse = 1'b0; derase = 1'b0; daddr = 16'h0000;
        dwd = 8'h00; creq = 1'b0; cwe = 1'b0; caddr = 16'h0000; cwd = 8'h00; ifreq = 1'b0; ifa = 16'h0000;
        dly = 4'h1;
        key = $random(seed);
        if (key == UNLOCK_KEY) key = ~key;
        img = {$random(seed), $random(seed), 8'($random(seed))};
        img[39:24] = 16'hFFFF;
        boot();
        chk(lck, 1'b1);
        chk(ardy, 1'b1);
        chk(wwin, img[7:4]);
        chk(wper, img[3:0]);
        chk(bod, img[15:8]);
        chk(osc, img[23:16]);
        chk(s0, img[47:40]);
        chk(s1, img[55:48]);
        chk(csz, img[63:56]);
        chk(bsz, img[71:64]);
        dbg(16'h7800, 1'b0, 1'b0, 1'b0, 8'h00, 9'h1FF);
        dbg(16'h1400, 1'b0, 1'b0, 1'b0, 8'h00, 9'h1FF);
        dbg(16'h1050, 1'b0, 1'b0, 1'b0, 8'h00, 9'h1FF);
        dbg(16'h1085, 1'b1, 1'b1, 1'b0, 8'h3C, 9'h000);
        dbg(16'h1085, 1'b0, 1'b0, 1'b0, 8'h00, 9'h1FF);
        cpu(16'h1085, 1'b0, 8'h00, 9'h13C);
        cpu(16'h1086, 1'b1, 8'h5A, 9'h000);
        cpu(16'h1086, 1'b0, 8'h00, 9'h15A);
        cpu(16'h1050, 1'b1, 8'h00, 9'h000);
        cpu(16'h1050, 1'b0, 8'h00, {1'b1, img[7:0]});
        dbg(16'h0000, 1'b0, 1'b0, 1'b1, 8'h00, 9'h000);
        chk(lck, 1'b0);
        cpu(16'h1085, 1'b0, 8'h00, 9'h13C);
        dly = 4'h4;
        dbg(16'h7FFF, 1'b0, 1'b0, 1'b0, 8'h00, 9'h15A);
        dbg(16'h7801, 1'b1, 1'b0, 1'b0, 8'hC3, 9'h000);
        chk(mwe, 1'b1);
        chk(mwd, 8'hC3);
        dbg(16'h15F8, 1'b0, 1'b0, 1'b0, 8'h00, 9'h15D);
        dbg(16'h1085, 1'b0, 1'b0, 1'b0, 8'h00, 9'h13C);
        dbg(16'h1050, 1'b1, 1'b0, 1'b0, 8'h77, 9'h000);
        chk(nva, 16'h1050);
        chk(nvd, 8'h77);
        cpu(16'h1050, 1'b0, 8'h00, 9'h177);
        chk(wwin, img[7:4]);
        img[7:0] = 8'h77;
        key = UNLOCK_KEY;
        boot();
        chk(wwin, 4'h7);
        chk(lck, 1'b0);
        ifreq = 1'b1; ifa = 16'h7A00;
        @(posedge clk);
        #2 ifa = 16'h8000;
        chk(ifault, 1'b1);
        @(posedge clk);
        #2 ifreq = 1'b0;
        chk(ifault, 1'b0);
        chk(stk, 16'h7FFF);
        repeat (3) @(posedge clk);
        summarize();
    end
endmodule : debug_access_lock_and_fuses_tb
